// *** verilog/hfcs_pkg.sv ***
package hfcs_pkg;
  // Radio frame length in chips and the default offset step in chips.
  localparam int unsigned FRAME_CHIPS    = 38400;
  localparam int unsigned OFFSET_STEP    = 512;
  // Default offset steps per frame; the initial load subtracts whole frames.
  localparam int unsigned STEPS_PER_FRM  = FRAME_CHIPS / OFFSET_STEP;
  // Widths: counter modulo 256, cell frame number 0..4095, offset 0..599.
  localparam int unsigned CFN_W          = 8;
  localparam int unsigned SFN_W          = 12;
  localparam int unsigned DEFAULT_FRAME_OFFSET_W         = 10;
  localparam int unsigned CHIP_W         = 16;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  // Register byte offsets.
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_CFG       = 8'h04;
  localparam logic [7:0]  ADDR_DEFAULT_FRAME_OFFSET      = 8'h08;
  localparam logic [7:0]  ADDR_SWITCH    = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS    = 8'h10;
  localparam logic [7:0]  ADDR_COUNT     = 8'h14;
  localparam logic [7:0]  ADDR_REPORT    = 8'h18;
  // Command bits of the control register, each acting once per write.
  localparam int unsigned CTRL_ENTER     = 0;
  localparam int unsigned CTRL_MULTI     = 1;
  localparam int unsigned CTRL_MEASURE   = 2;
  localparam int unsigned CTRL_HANDOVER  = 3;
  localparam int unsigned CTRL_LEAVE     = 4;
  localparam int unsigned CTRL_CLR_DONE  = 5;
  // Configuration bits.
  localparam int unsigned CFG_TDD        = 0;
  localparam int unsigned CFG_TO_TDD     = 1;
  localparam int unsigned CFG_NEW_OFFSET = 2;
  localparam int unsigned CFG_ARM        = 3;
  localparam int unsigned CFG_W          = 4;
  // Report field positions.
  localparam int unsigned REP_CHIP_LSB   = 8;
  localparam int unsigned REP_FRM_VLD    = 24;
  localparam int unsigned REP_CHIP_VLD   = 25;
  // Reset values.
  localparam logic [3:0]  CFG_RST        = 4'h0;
  localparam logic [9:0]  DEFAULT_FRAME_OFFSET_RST       = 10'h000;
  localparam logic [7:0]  SWITCH_RST     = 8'h00;
  // Counter phase of the handset.
  typedef enum logic [1:0] {
    HFCS_COMMON,
    HFCS_DCH,
    HFCS_REINIT
  } hfcs_state_e;
endpackage

// *** verilog/hfcs_calc_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Operands and results passed between the counter core and its arithmetic.
interface hfcs_calc_if;
  import hfcs_pkg::*;
  logic                tdd;
  logic [SFN_W-1:0]    cell_frame_number;
  logic [DEFAULT_FRAME_OFFSET_W-1:0]   default_frame_offset;
  logic [CFN_W-1:0]    connection_frame_count;
  logic [SFN_W-1:0]    meas_sfn;
  logic [CFN_W-1:0]    init_cfn;
  logic [CFN_W-1:0]    frame_diff;
  modport calc (input tdd, cell_frame_number, default_frame_offset, connection_frame_count, meas_sfn, output init_cfn, frame_diff);
  modport user (output tdd, cell_frame_number, default_frame_offset, connection_frame_count, meas_sfn, input init_cfn, frame_diff);
endinterface
`default_nettype wire

// *** verilog/hfcs_calc.sv ***
`timescale 1ns/10ps
`default_nettype none
module hfcs_calc
  import hfcs_pkg::*;
(
  hfcs_calc_if.calc cif
);
  localparam logic [DEFAULT_FRAME_OFFSET_W-1:0] STEPS = DEFAULT_FRAME_OFFSET_W'(STEPS_PER_FRM);
  logic [DEFAULT_FRAME_OFFSET_W-1:0] frames_back;

  // The chip-exact formula reduces to whole frames: subtracting the offset
  // rounds the frame number down, so the frames removed are the offset in
  // frames rounded up. This avoids a 28-bit multiplier and divider.
  always_comb begin
    frames_back = (cif.default_frame_offset + STEPS - DEFAULT_FRAME_OFFSET_W'(1)) / STEPS;
    if (cif.tdd) begin
      cif.init_cfn = cif.cell_frame_number[CFN_W-1:0] - CFN_W'(cif.default_frame_offset);
    end else begin
      cif.init_cfn = cif.cell_frame_number[CFN_W-1:0] - frames_back[CFN_W-1:0];
    end
  end

  // Eight-bit wrap makes every difference non-negative modulo 256.
  assign cif.frame_diff = cif.meas_sfn[CFN_W-1:0] - cif.connection_frame_count;
endmodule
`default_nettype wire

// *** verilog/hfcs_top.sv ***
// Functional notes
// - FDD single link: load from frame number, offset.
// - TDD entry: load frame number minus offset.
// - Increment counter every frame, wrapping at 256.
// - TDD common channels follow frame number mod 256.
// - Multi-link setup: report frame and chip differences.
// - After measurements, load from reference cell.
// - FDD handover difference; no chip to TDD.
// - TDD handover difference, else default value.
// - Known difference: keep counter across handover.
// - New offset: reload on reading target frame.
// - Switch configuration at signalled counter value.
// - Common states: paging full, others mod 256.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module hfcs_top
  import hfcs_pkg::*;
#(
  parameter logic [7:0] UNMEASURED_DIFF = 8'hFF
) (
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_N_I,
  input  wire logic              FRAME_STB_I,
  input  wire logic [SFN_W-1:0]  CELL_SFN_I,
  input  wire logic              CELL_SFN_VLD_I,
  input  wire logic [SFN_W-1:0]  MEAS_SFN_I,
  input  wire logic [CHIP_W-1:0] MEAS_CHIP_I,
  input  wire logic              MEAS_VLD_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WR_DATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic [DATA_W-1:0]      RD_DATA_O,
  output logic [CFN_W-1:0]       CFN_O,
  output logic [SFN_W-1:0]       PCH_CFN_O,
  output logic [CFN_W-1:0]       COMMON_CFN_O,
  output logic                   DCH_O,
  output logic                   L1_SWITCH_O
);
  // Whole state of the block, registered in one place.
  typedef struct packed {
    hfcs_state_e         state;
    logic [CFN_W-1:0]    connection_frame_count;
    logic [SFN_W-1:0]    paging_channel;
    logic [CFN_W-1:0]    common;
    logic                pend_load;
    logic [CFG_W-1:0]    cfg;
    logic [DEFAULT_FRAME_OFFSET_W-1:0]   default_frame_offset;
    logic [CFN_W-1:0]    sw;
    logic                done;
    logic                sw_pulse;
    logic [CFN_W-1:0]    rep_frame;
    logic [CHIP_W-1:0]   rep_chip;
    logic                rep_fvld;
    logic                rep_cvld;
    logic [DATA_W-1:0]   rdata;
  } hfcs_regs_s;

  hfcs_regs_s   cur_r;
  hfcs_regs_s   cur_nxt;
  hfcs_calc_if  cif ();

  logic         wr_ctrl;
  logic         cmd_enter;
  logic         cmd_multi;
  logic         cmd_measure;
  logic         cmd_handover;
  logic         cmd_leave;
  logic         cmd_clr_done;
  logic [DATA_W-1:0] rd_mux;

  // Operands for the shared arithmetic come from live state and pins.
  assign cif.tdd      = cur_r.cfg[CFG_TDD];
  assign cif.cell_frame_number      = CELL_SFN_I;
  assign cif.default_frame_offset     = cur_r.default_frame_offset;
  assign cif.connection_frame_count      = cur_r.connection_frame_count;
  assign cif.meas_sfn = MEAS_SFN_I;

  hfcs_calc u_calc (
    .cif (cif.calc)
  );

  // Command decode of the control register; every bit is a one-shot.
  assign wr_ctrl      = WR_I && (ADDR_I == ADDR_CTRL);
  assign cmd_enter    = wr_ctrl && WR_DATA_I[CTRL_ENTER];
  assign cmd_multi    = wr_ctrl && WR_DATA_I[CTRL_MULTI];
  assign cmd_measure  = wr_ctrl && WR_DATA_I[CTRL_MEASURE];
  assign cmd_handover = wr_ctrl && WR_DATA_I[CTRL_HANDOVER];
  assign cmd_leave    = wr_ctrl && WR_DATA_I[CTRL_LEAVE];
  assign cmd_clr_done = wr_ctrl && WR_DATA_I[CTRL_CLR_DONE];

  // Read multiplexer; unmapped and write-only addresses read as zero.
  always_comb begin
    rd_mux = '0;
    case (ADDR_I)
      ADDR_CFG: begin
        rd_mux[CFG_W-1:0] = cur_r.cfg;
      end
      ADDR_DEFAULT_FRAME_OFFSET: begin
        rd_mux[DEFAULT_FRAME_OFFSET_W-1:0] = cur_r.default_frame_offset;
      end
      ADDR_SWITCH: begin
        rd_mux[CFN_W-1:0] = cur_r.sw;
      end
      ADDR_STATUS: begin
        rd_mux[1:0] = cur_r.state;
        rd_mux[2]   = cur_r.pend_load;
        rd_mux[3]   = cur_r.done;
      end
      ADDR_COUNT: begin
        rd_mux[CFN_W-1:0]           = cur_r.connection_frame_count;
        rd_mux[CFN_W+SFN_W-1:CFN_W] = cur_r.paging_channel;
      end
      ADDR_REPORT: begin
        rd_mux[CFN_W-1:0]                         = cur_r.rep_frame;
        rd_mux[REP_CHIP_LSB+CHIP_W-1:REP_CHIP_LSB] = cur_r.rep_chip;
        rd_mux[REP_FRM_VLD]                       = cur_r.rep_fvld;
        rd_mux[REP_CHIP_VLD]                      = cur_r.rep_cvld;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Next-state logic. Commands set state, flags and reports at once; the counter itself moves
  // solely on the frame strobe so it never slips against the air frame.
  always_comb begin
    cur_nxt          = cur_r;
    cur_nxt.sw_pulse = 1'b0;
    cur_nxt.rdata    = RD_I ? rd_mux : '0;

    // Plain register writes.
    if (WR_I && (ADDR_I == ADDR_CFG)) begin
      cur_nxt.cfg = WR_DATA_I[CFG_W-1:0];
    end
    if (WR_I && (ADDR_I == ADDR_DEFAULT_FRAME_OFFSET)) begin
      cur_nxt.default_frame_offset = WR_DATA_I[DEFAULT_FRAME_OFFSET_W-1:0];
    end
    if (WR_I && (ADDR_I == ADDR_SWITCH)) begin
      cur_nxt.sw = WR_DATA_I[CFN_W-1:0];
    end
    if (cmd_clr_done) begin
      cur_nxt.done = 1'b0;
    end

    // Entry to the dedicated state, single or reference-cell based.
    if (cmd_enter || cmd_multi) begin
      cur_nxt.pend_load = 1'b1;
    end

    // Difference report for multi-link setup and handover targets.
    if (cmd_measure) begin
      if (MEAS_VLD_I) begin
        cur_nxt.rep_frame = cif.frame_diff;
        cur_nxt.rep_fvld  = 1'b1;
      end else begin
        cur_nxt.rep_frame = UNMEASURED_DIFF;
        cur_nxt.rep_fvld  = 1'b0;
      end
      // Chip timing is reported in FDD, but never for a handover into TDD.
      cur_nxt.rep_cvld = !cur_r.cfg[CFG_TDD] && !cur_r.cfg[CFG_TO_TDD];
      cur_nxt.rep_chip = cur_nxt.rep_cvld ? MEAS_CHIP_I : '0;
    end

    // Handover: a known difference keeps the counter, a new offset reloads.
    if (cmd_handover && (cur_r.state != HFCS_COMMON)) begin
      if (cur_r.cfg[CFG_NEW_OFFSET]) begin
        cur_nxt.state = HFCS_REINIT;
      end else begin
        cur_nxt.state = HFCS_DCH;
      end
    end

    if (cmd_leave) begin
      cur_nxt.state     = HFCS_COMMON;
      cur_nxt.pend_load = 1'b0;
    end

    // Frame boundary work; a pending load beats the increment.
    if (FRAME_STB_I) begin
      cur_nxt.paging_channel    = CELL_SFN_I;
      cur_nxt.common = CELL_SFN_I[CFN_W-1:0];
      case (cur_nxt.state)
        HFCS_COMMON: begin
          if (cur_nxt.pend_load) begin
            cur_nxt.connection_frame_count       = cif.init_cfn;
            cur_nxt.state     = HFCS_DCH;
            cur_nxt.pend_load = 1'b0;
          end else begin
            cur_nxt.connection_frame_count = CELL_SFN_I[CFN_W-1:0];
          end
        end
        HFCS_DCH: begin
          if (cur_nxt.pend_load) begin
            cur_nxt.connection_frame_count       = cif.init_cfn;
            cur_nxt.pend_load = 1'b0;
          end else begin
            cur_nxt.connection_frame_count = cur_r.connection_frame_count + CFN_W'(1);
          end
        end
        HFCS_REINIT: begin
          // Keep counting on the old value until the target is read.
          if (CELL_SFN_VLD_I) begin
            cur_nxt.connection_frame_count       = cif.init_cfn;
            cur_nxt.state     = HFCS_DCH;
            cur_nxt.pend_load = 1'b0;
          end else begin
            cur_nxt.connection_frame_count = cur_r.connection_frame_count + CFN_W'(1);
          end
        end
        default: begin
          cur_nxt.state = HFCS_COMMON;
        end
      endcase

      // Synchronised configuration change at the signalled counter value.
      if (cur_r.cfg[CFG_ARM] && (cur_nxt.state != HFCS_COMMON)
          && (cur_nxt.connection_frame_count == cur_r.sw)) begin
        cur_nxt.sw_pulse     = 1'b1;
        cur_nxt.done         = 1'b1;
        cur_nxt.cfg[CFG_ARM] = 1'b0;
      end
    end
  end

  // Single state register; reset puts the block in the common state.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cur_r       <= '0;
      cur_r.state <= HFCS_COMMON;
      cur_r.cfg   <= CFG_RST;
      cur_r.default_frame_offset  <= DEFAULT_FRAME_OFFSET_RST;
      cur_r.sw    <= SWITCH_RST;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign RD_DATA_O    = cur_r.rdata;
  assign CFN_O        = cur_r.connection_frame_count;
  assign PCH_CFN_O    = cur_r.paging_channel;
  assign COMMON_CFN_O = cur_r.common;
  assign DCH_O        = (cur_r.state != HFCS_COMMON);
  assign L1_SWITCH_O  = cur_r.sw_pulse;
endmodule
`default_nettype wire

// *** tb/hfcs_cell_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Serving cell side: the radio frame strobe and the cell frame number.
// The number steps with the strobe, so it is current at the sampling edge.
module hfcs_cell_model
  import hfcs_pkg::*;
#(
  parameter int               FRM_CYC   = 40,
  parameter logic [SFN_W-1:0] SFN_START = 12'hFF8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  output logic                  frame_stb_o,
  output logic [SFN_W-1:0]      cell_sfn_o
);
  int cnt;
  // A fixed frame period; a real cell never stretches a radio frame.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      frame_stb_o <= 1'b0;
      cell_sfn_o <= SFN_START;
    end else begin
      frame_stb_o <= (cnt == FRM_CYC - 1);
      cnt <= (cnt == FRM_CYC - 1) ? 0 : cnt + 1;
      if (cnt == FRM_CYC - 1) cell_sfn_o <= cell_sfn_o + 12'h001;
    end
  end
endmodule
`default_nettype wire

// *** tb/hfcs_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// Watches the top ports; helper state mirrors what software wrote.
module hfcs_asserts
  import hfcs_pkg::*;
(
  input wire logic              REF_CLK_I,
  input wire logic              RST_N_I,
  input wire logic              FRAME_STB_I,
  input wire logic [SFN_W-1:0]  CELL_SFN_I,
  input wire logic              CELL_SFN_VLD_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WR_DATA_I,
  input wire logic              WR_I,
  input wire logic              RD_I,
  input wire logic [DATA_W-1:0] RD_DATA_O,
  input wire logic [CFN_W-1:0]  CFN_O,
  input wire logic [SFN_W-1:0]  PCH_CFN_O,
  input wire logic [CFN_W-1:0]  COMMON_CFN_O,
  input wire logic              DCH_O,
  input wire logic              L1_SWITCH_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic       armed_r;
  logic [7:0] sw_r;
  // Armed once a strobe has used up every command written before it.
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      armed_r <= 1'b0;
      sw_r <= 8'h00;
    end else begin
      if (WR_I && ADDR_I == ADDR_CTRL) armed_r <= 1'b0;
      else if (FRAME_STB_I) armed_r <= 1'b1;
      if (WR_I && ADDR_I == ADDR_SWITCH) sw_r <= WR_DATA_I[7:0];
    end
  end
  property p_hold; !FRAME_STB_I |=> $stable(CFN_O); endproperty
  a_hold: assert property (p_hold) else $error("count moved off strobe");
  property p_pch; FRAME_STB_I |=> PCH_CFN_O == $past(CELL_SFN_I); endproperty
  a_pch: assert property (p_pch) else $error("paging count wrong");
  property p_comm; FRAME_STB_I |=> COMMON_CFN_O == $past(CELL_SFN_I[7:0]); endproperty
  a_comm: assert property (p_comm) else $error("common count wrong");
  property p_fach; FRAME_STB_I && !DCH_O ##1 !DCH_O |-> CFN_O == $past(CELL_SFN_I[7:0]);
  endproperty
  a_fach: assert property (p_fach) else $error("common state count wrong");
  property p_rise; $rose(DCH_O) |-> $past(FRAME_STB_I); endproperty
  a_rise: assert property (p_rise) else $error("entry off strobe");
  property p_incr; FRAME_STB_I && armed_r && DCH_O && !CELL_SFN_VLD_I && !WR_I
    |=> CFN_O == $past(CFN_O) + 8'h01; endproperty
  a_incr: assert property (p_incr) else $error("no increment");
  property p_sw; L1_SWITCH_O |-> $past(FRAME_STB_I) && DCH_O && CFN_O == sw_r; endproperty
  a_sw: assert property (p_sw) else $error("switch at wrong count");
  property p_cnt; RD_I && ADDR_I == ADDR_COUNT
    |=> RD_DATA_O == {12'h000, $past(PCH_CFN_O), $past(CFN_O)}; endproperty
  a_cnt: assert property (p_cnt) else $error("count read wrong");
  c_sw: cover property (L1_SWITCH_O);
  c_enter: cover property ($rose(DCH_O));
  c_incr: cover property (FRAME_STB_I && armed_r && DCH_O);
endmodule
bind hfcs_top hfcs_asserts hfcs_asserts_inst (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
  .FRAME_STB_I(FRAME_STB_I), .CELL_SFN_I(CELL_SFN_I), .CELL_SFN_VLD_I(CELL_SFN_VLD_I),
  .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .WR_I(WR_I), .RD_I(RD_I), .RD_DATA_O(RD_DATA_O),
  .CFN_O(CFN_O), .PCH_CFN_O(PCH_CFN_O), .COMMON_CFN_O(COMMON_CFN_O), .DCH_O(DCH_O),
  .L1_SWITCH_O(L1_SWITCH_O));
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import hfcs_pkg::*;
  localparam logic [7:0] UNM = 8'hFF;
  logic             clk, rst_n, stb, sfn_vld, mvld, wr, rd, l1, dch, t, fv, cv;
  logic [SFN_W-1:0] cell_frame_number, msfn, paging_channel, s;
  logic [15:0]      mchip;
  logic [7:0]       addr, connection_frame_count, ccfn, c, fd;
  logic [31:0]      wdat, rdat, m;
  logic [7:0]       ra [6] = '{ADDR_CTRL, ADDR_CFG, ADDR_DEFAULT_FRAME_OFFSET, ADDR_SWITCH, ADDR_STATUS, 8'h1C};
  int               seed = 74, err_total = 0, checked = 0, cyc = 0, default_frame_offset, d2;
  hfcs_cell_model #(.FRM_CYC(40)) hfcs_cell_model_inst (.clk_i(clk), .rst_n_i(rst_n),
    .frame_stb_o(stb), .cell_sfn_o(cell_frame_number));
  hfcs_top #(.UNMEASURED_DIFF(UNM)) hfcs_top_inst (.REF_CLK_I(clk), .RST_N_I(rst_n),
    .FRAME_STB_I(stb), .CELL_SFN_I(cell_frame_number), .CELL_SFN_VLD_I(sfn_vld), .MEAS_SFN_I(msfn),
    .MEAS_CHIP_I(mchip), .MEAS_VLD_I(mvld), .ADDR_I(addr), .WR_DATA_I(wdat), .WR_I(wr),
    .RD_I(rd), .RD_DATA_O(rdat), .CFN_O(connection_frame_count), .PCH_CFN_O(paging_channel), .COMMON_CFN_O(ccfn),
    .DCH_O(dch), .L1_SWITCH_O(l1));
  always #10 clk = ~clk;
  // A hang is cut short well past the roughly 1,420 cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, e);
    checked++;
    if (got !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, e);
    end
  endtask
  // Each access leaves a gap cycle so a strobe is never raised twice in one step.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, mk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdat & mk, e & mk);
    @(posedge clk);
  endtask
  // Returns just after a strobe edge with the frame number the design sampled.
  task automatic frame();
    @(posedge clk);
    while (stb !== 1'b1) @(posedge clk);
    s = cell_frame_number;
    #1;
  endtask
  function automatic logic [7:0] f_init(input int sf, d, input logic td);
    int x;
    if (td) return 8'(sf - d);
    x = sf * 38400 - d * 512;
    if (x < 0) x = x - 38399;
    return 8'(x / 38400);
  endfunction
  initial begin
    clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdat = 32'h0;
    sfn_vld = 1'b0; mvld = 1'b0; msfn = 12'h000; mchip = 16'h0000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ra[k]) rdc(ra[k], 32'h0, 32'hFFFFFFFF);
    wr_reg(ADDR_CTRL, 32'h8);
    frame();
    cmp(connection_frame_count, s[7:0]);
    for (int i = 0; i < 4; i++) begin
      t = i[0];
      default_frame_offset = (i == 0) ? 599 : (i == 1) ? 0 : $unsigned($random(seed)) % 600;
      frame();
      wr_reg(ADDR_CFG, 32'(t));
      wr_reg(ADDR_DEFAULT_FRAME_OFFSET, 32'(default_frame_offset));
      wr_reg(ADDR_CTRL, (i == 2) ? 32'h2 : 32'h1);
      frame();
      cmp(connection_frame_count, f_init(s, default_frame_offset, t));
      cmp(dch, 1'b1);
      c = connection_frame_count;
      frame();
      // Cast keeps the 255 to 0 wrap; a bare sum would widen to 32 bits.
      cmp(connection_frame_count, 8'(c + 8'h01));
      cmp(ccfn, s[7:0]);
      // Random cell to measure; the last pass cannot measure it.
      msfn <= 12'($random(seed));
      mchip <= 16'($random(seed));
      mvld <= (i != 3);
      wr_reg(ADDR_CFG, 32'(t) | ((i == 2) ? 32'h2 : 32'h0));
      wr_reg(ADDR_CTRL, 32'h4);
      fv = (i != 3);
      cv = !t && i != 2;
      fd = fv ? 8'(msfn - connection_frame_count) : UNM;
      m = 32'h010000FF | (fv ? 32'h02000000 : 32'h0) | ((fv && cv) ? 32'h00FFFF00 : 32'h0);
      rdc(ADDR_REPORT, {6'h00, cv, fv, mchip, fd}, m);
      c = connection_frame_count;
      if (i < 2) begin
        wr_reg(ADDR_CFG, 32'(t));
        wr_reg(ADDR_CTRL, 32'h8);
        frame();
        cmp(connection_frame_count, 8'(c + 8'h01));
      end else begin
        d2 = $unsigned($random(seed)) % 600;
        wr_reg(ADDR_DEFAULT_FRAME_OFFSET, 32'(d2));
        wr_reg(ADDR_CFG, 32'(t) | 32'h4);
        wr_reg(ADDR_CTRL, 32'h8);
        frame();
        cmp(connection_frame_count, 8'(c + 8'h01));
        rdc(ADDR_STATUS, 32'h2, 32'h3);
        sfn_vld <= 1'b1;
        frame();
        cmp(connection_frame_count, f_init(s, d2, t));
        sfn_vld <= 1'b0;
      end
      frame();
      c = connection_frame_count + 8'h02;
      wr_reg(ADDR_SWITCH, {24'h0, c});
      wr_reg(ADDR_CFG, 32'(t) | 32'h8);
      frame();
      cmp(l1, 1'b0);
      frame();
      cmp(l1, 1'b1);
      rdc(ADDR_STATUS, 32'h8, 32'h8);
      wr_reg(ADDR_CTRL, 32'h20);
      rdc(ADDR_STATUS, 32'h0, 32'h8);
      wr_reg(ADDR_CTRL, 32'h10);
      frame();
      cmp(dch, 1'b0);
      cmp(paging_channel, s);
      rdc(ADDR_COUNT, {12'h000, s, s[7:0]}, 32'hFFFFFFFF);
    end
    final_report();
  end
endmodule
`default_nettype wire
